//--- design/compressor_map.vh
`ifndef COMPRESSOR_MAP_VH
`define COMPRESSOR_MAP_VH

// Register byte addresses
`define A_CTRL   8'h00
`define A_LOWER  8'h04
`define A_UPPER  8'h08
`define A_IDLE   8'h0c
`define A_HOLD   8'h10
`define A_SDLY   8'h14
`define A_CMD    8'h18
`define A_STAT   8'h1c
`define A_PRES   8'h20

// Control fields
`define CTRL_MODE_LO 0
`define CTRL_MODE_HI 1
`define CTRL_LIM     2
`define CTRL_ARST    3
`define CTRL_NET     4
`define CTRL_OWN     5
`define CTRL_ID_LO   8
`define CTRL_ID_HI   10
`define CMD_LOAD     0
`define CMD_UNLOAD   1

// Operating modes
`define MODE_AUTO  2'h0
`define MODE_CONST 2'h1
`define MODE_EXT   2'h2
`define MODE_LOCAL 2'h3

// Reset values, pressure in 0.1 bar, times in seconds
`define CTRL_RST  11'h000
`define LOWER_RST 16'h003c
`define UPPER_RST 16'h0050
`define IDLE_RST  16'h00b4
`define HOLD_RST  16'h0005
`define SDLY_RST  16'h000a
`define SRCH_SEC  16'h001e
`define NODES     4

// Timing
`define CLK_NS     8
`define SEC_NS     1000000000
`define SEC_CYCLES (`SEC_NS / `CLK_NS)

`endif

//--- design/pin_sync.v
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rstn,
  // Pins in, synchronised out
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule
`default_nettype wire

//--- design/sec_timer.v
`timescale 1ns/100ps
`default_nettype none
module sec_timer #(
  parameter W = 16
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rstn,
  // Second tick and control
  input  wire         tick,
  input  wire         run,
  input  wire [W-1:0] limit,
  output wire         done
);
  reg [W-1:0] cnt_r;

  // Dropping run restarts the count from zero
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      cnt_r <= {W{1'b0}};
    else if (!run)
      cnt_r <= {W{1'b0}};
    else if (tick && cnt_r < limit)
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
  end

  assign done = run && (cnt_r >= limit);
endmodule
`default_nettype wire

//--- design/compressor_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "compressor_map.vh"
module compressor_ctrl #(
  parameter PW        = 16,
  parameter SEC_TICKS = `SEC_CYCLES
) (
  // Clock and reset
  input  wire          clock,
  input  wire          rstn,
  // Register port
  input  wire [7:0]    addr,
  input  wire [31:0]   wdata,
  input  wire          wr,
  input  wire          rd,
  input  wire          remote_src,
  output wire [31:0]   rdata,
  // Pressure sample
  input  wire [PW-1:0] pressure,
  input  wire          pressure_tick,
  // Panel and field pins
  input  wire          external_command_line_n,
  input  wire          start_btn,
  input  wire          stop_btn,
  input  wire          net_menu,
  input  wire          power_restart,
  // Network link status
  input  wire [3:0]    peer_present,
  input  wire [3:0]    peer_active,
  // Compressor outputs
  output wire          load_valve,
  output wire          motor_run,
  output wire          confirm,
  output wire          ready,
  output wire          remote_disabled,
  // Network outputs
  output wire          net_active,
  output wire [3:0]    unit_start,
  output wire          search
);
  localparam S_STOP  = 5'b00001;
  localparam S_READY = 5'b00010;
  localparam S_LOAD  = 5'b00100;
  localparam S_IDLE  = 5'b01000;
  localparam S_WAIT  = 5'b10000;

  // Pins
  wire [4:0] pin_s;
  reg  [4:0] pin_prev_r;

  pin_sync #(.W(5)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    // Line inverted ahead of the flops so reset reads it idle, not active
    .din   ({power_restart, net_menu, stop_btn, start_btn, ~external_command_line_n}),
    .dout  (pin_s)
  );

  wire ext_act   = pin_s[0];
  wire ext_on    = ext_act & ~pin_prev_r[0];
  wire ext_off   = ~ext_act & pin_prev_r[0];
  wire start_p   = pin_s[1] & ~pin_prev_r[1];
  wire stop_p    = pin_s[2] & ~pin_prev_r[2];
  wire in_menu   = pin_s[3];
  wire restart_p = pin_s[4] & ~pin_prev_r[4];

  // Registers
  reg  [10:0]   ctrl_r;
  reg  [PW-1:0] lower_r;
  reg  [PW-1:0] upper_r;
  reg  [15:0]   idle_r;
  reg  [15:0]   hold_r;
  reg  [15:0]   sdly_r;
  reg  [PW-1:0] pres_r;
  reg  [31:0]   rdata_r;
  reg           cmd_load_r;
  reg           cmd_unload_r;

  wire [1:0] mode   = ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire       is_ext = (mode == `MODE_EXT);
  wire       is_con = (mode == `MODE_CONST);
  wire       lim_en = ctrl_r[`CTRL_LIM];
  wire [2:0] own_id = ctrl_r[`CTRL_ID_HI:`CTRL_ID_LO];
  // Remote writers have no say in local mode
  wire       wr_ok  = wr & ~(remote_src & (mode == `MODE_LOCAL));

  // Second tick
  reg [31:0] pre_r;
  reg        sec_r;
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 32'h0000_0000;
      sec_r <= 1'b0;
    end else if (pre_r >= SEC_TICKS - 1) begin
      pre_r <= 32'h0000_0000;
      sec_r <= 1'b1;
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
      sec_r <= 1'b0;
    end
  end

  // Threshold crossings, judged only on a fresh sample
  wire p_high = pressure_tick & (pressure >= upper_r);
  wire p_low  = pressure_tick & (pressure < lower_r);
  wire p_at   = pressure_tick & (pressure <= lower_r);

  // State machine
  reg  [4:0] st_r;
  reg  [4:0] st_nxt;
  reg        disabled_r;
  reg        rpend_r;
  reg        valve_r;
  reg        motor_r;
  reg        confirm_r;
  reg        ready_r;
  wire       idle_done;
  wire       hold_done;
  reg  [3:0] ustart_r;

  wire [3:0] own_bit = (own_id >= 3'h1 && own_id <= 3'h4 && ctrl_r[`CTRL_OWN]) ?
                       (4'h1 << (own_id - 3'h1)) : 4'h0;
  wire own_start = (start_p & ~in_menu) | (|(ustart_r & own_bit));
  wire own_stop  = stop_p & ~in_menu;
  wire rem_ok    = is_ext & ~lim_en;
  wire ext_go    = ext_act & (~rpend_r | hold_done);

  sec_timer u_idle (
    .clock (clock),
    .rstn  (rstn),
    .tick  (sec_r),
    .run   (st_r == S_IDLE),
    .limit (idle_r),
    .done  (idle_done)
  );

  sec_timer u_hold (
    .clock (clock),
    .rstn  (rstn),
    .tick  (sec_r),
    .run   ((st_r == S_READY) & ext_act),
    .limit (hold_r),
    .done  (hold_done)
  );

  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_STOP: begin
        if (own_start)
          st_nxt = is_ext ? S_READY : S_LOAD;
      end
      S_READY: begin
        if (is_ext && lim_en && ext_act)
          st_nxt = S_WAIT;
        else if (rem_ok && (ext_go || cmd_load_r))
          st_nxt = S_LOAD;
      end
      S_LOAD: begin
        if (rem_ok) begin
          if (ext_off || cmd_unload_r)
            st_nxt = S_IDLE;
        end else if (is_ext && !ext_act)
          st_nxt = S_READY;
        else if (p_high)
          st_nxt = S_IDLE;
      end
      S_IDLE: begin
        if (rem_ok) begin
          if (ext_on || cmd_load_r)
            st_nxt = S_LOAD;
          else if (idle_done)
            st_nxt = S_READY;
        end else if (is_ext && !ext_act)
          st_nxt = S_READY;
        else if (is_con) begin
          if (p_at)
            st_nxt = S_LOAD;
        end else if (p_low)
          st_nxt = S_LOAD;
        else if (idle_done)
          st_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (is_ext && !ext_act)
          st_nxt = S_READY;
        else if (p_low)
          st_nxt = S_LOAD;
      end
      default: st_nxt = S_STOP;
    endcase
    if (restart_p && ctrl_r[`CTRL_ARST] && is_ext && !disabled_r)
      st_nxt = S_READY;
    if (is_ext && disabled_r && !own_start)
      st_nxt = S_STOP;
    if (own_stop)
      st_nxt = S_STOP;
  end

  wire run_nxt = (st_nxt == S_LOAD) | (st_nxt == S_IDLE);

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r       <= S_STOP;
      disabled_r <= 1'b0;
      rpend_r    <= 1'b0;
      valve_r    <= 1'b0;
      motor_r    <= 1'b0;
      confirm_r  <= 1'b0;
      ready_r    <= 1'b0;
      pin_prev_r <= 5'h00;
    end else begin
      st_r       <= st_nxt;
      pin_prev_r <= pin_s;
      valve_r    <= (st_nxt == S_LOAD);
      motor_r    <= run_nxt;
      ready_r    <= (st_nxt == S_READY);
      // Held through unloaded idling, dropped when the motor stops
      confirm_r  <= confirm_r ? run_nxt : (st_nxt == S_LOAD);
      if (own_start)
        disabled_r <= 1'b0;
      else if (own_stop && is_ext)
        disabled_r <= 1'b1;
      if (restart_p && ctrl_r[`CTRL_ARST] && is_ext)
        rpend_r <= 1'b1;
      else if (st_nxt != S_READY)
        rpend_r <= 1'b0;
    end
  end

  // Network supervisor
  reg        netact_r;
  reg  [3:0] pend_r;
  reg        gap_r;
  reg        search_r;
  wire       sdly_done;
  wire       srch_done;
  wire       is_sup  = ctrl_r[`CTRL_NET];
  // Peers holding our own id are dropped, ids must be unique
  wire [3:0] members = (peer_present & peer_active & ~own_bit) |
                       (own_bit & {4{st_r != S_STOP}});
  wire       nstart  = is_sup & in_menu & start_p;
  wire [3:0] pick    = pend_r & (~pend_r + 4'h1);

  // Gap counted in cycles, so no gap falls short of the delay by tick phase
  localparam [31:0] SEC_W = SEC_TICKS;
  wire [47:0] sdly_cyc = {32'h0000_0000, sdly_r} * {16'h0000, SEC_W};

  sec_timer #(.W(48)) u_sdly (
    .clock (clock),
    .rstn  (rstn),
    .tick  (1'b1),
    .run   (netact_r & gap_r),
    .limit (sdly_cyc),
    .done  (sdly_done)
  );

  sec_timer u_srch (
    .clock (clock),
    .rstn  (rstn),
    .tick  (sec_r),
    .run   (netact_r & ~search_r),
    .limit (`SRCH_SEC),
    .done  (srch_done)
  );

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      netact_r <= 1'b0;
      pend_r   <= 4'h0;
      gap_r    <= 1'b0;
      search_r <= 1'b0;
      ustart_r <= 4'h0;
    end else begin
      ustart_r <= 4'h0;
      search_r <= nstart | srch_done;
      if (!is_sup || (in_menu && stop_p) || (netact_r && members == 4'h0)) begin
        netact_r <= 1'b0;
        pend_r   <= 4'h0;
        gap_r    <= 1'b0;
      end else if (nstart) begin
        if (members != 4'h0) begin
          netact_r <= 1'b1;
          pend_r   <= members;
          gap_r    <= 1'b0;
        end
      end else if (netact_r) begin
        if (gap_r) begin
          if (sdly_done)
            gap_r <= 1'b0;
        end else if (pend_r != 4'h0) begin
          ustart_r <= pick;
          pend_r   <= pend_r & ~pick;
          gap_r    <= 1'b1;
        end
      end
    end
  end

  // Register writes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r       <= `CTRL_RST;
      lower_r      <= `LOWER_RST;
      upper_r      <= `UPPER_RST;
      idle_r       <= `IDLE_RST;
      hold_r       <= `HOLD_RST;
      sdly_r       <= `SDLY_RST;
      pres_r       <= {PW{1'b0}};
      cmd_load_r   <= 1'b0;
      cmd_unload_r <= 1'b0;
    end else begin
      if (pressure_tick)
        pres_r <= pressure;
      // Commands are latched in any state but stop, and only act in remote mode with the limit off
      cmd_load_r   <= wr_ok && addr == `A_CMD && wdata[`CMD_LOAD] &&
                      st_r != S_STOP;
      cmd_unload_r <= wr_ok && addr == `A_CMD && wdata[`CMD_UNLOAD] &&
                      st_r != S_STOP;
      if (wr_ok) begin
        case (addr)
          `A_CTRL:  ctrl_r  <= wdata[10:0];
          `A_LOWER: lower_r <= wdata[PW-1:0];
          `A_UPPER: upper_r <= wdata[PW-1:0];
          `A_IDLE:  idle_r  <= wdata[15:0];
          `A_HOLD:  hold_r  <= wdata[15:0];
          `A_SDLY:  sdly_r  <= wdata[15:0];
          default:  ;
        endcase
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  reg [31:0] rmux;
  always @* begin
    rmux = 32'h0000_0000;
    case (addr)
      `A_CTRL:  rmux[10:0]   = ctrl_r;
      `A_LOWER: rmux[PW-1:0] = lower_r;
      `A_UPPER: rmux[PW-1:0] = upper_r;
      `A_IDLE:  rmux[15:0]   = idle_r;
      `A_HOLD:  rmux[15:0]   = hold_r;
      `A_SDLY:  rmux[15:0]   = sdly_r;
      `A_STAT:  rmux[19:0]   = {members, pend_r, 1'b0, rpend_r, netact_r,
                                disabled_r, confirm_r, motor_r, valve_r, st_r};
      `A_PRES:  rmux[PW-1:0] = pres_r;
      default:  rmux = 32'h0000_0000;
    endcase
  end

  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      rdata_r <= 32'h0000_0000;
    else
      rdata_r <= rd ? rmux : 32'h0000_0000;
  end

  assign rdata           = rdata_r;
  assign load_valve      = valve_r;
  assign motor_run       = motor_r;
  assign confirm         = confirm_r;
  assign ready           = ready_r;
  assign remote_disabled = disabled_r;
  assign net_active      = netact_r;
  assign unit_start      = ustart_r;
  assign search          = search_r;
endmodule
`default_nettype wire

//--- test/compressor_chk.sv
`timescale 1ns/100ps
`default_nettype none
module compressor_chk #(
  parameter PW        = 16,
  parameter SEC_TICKS = 10
) (
  // Clock and reset
  input wire logic          clock,
  input wire logic          rstn,
  // Register port
  input wire logic [7:0]    addr,
  input wire logic [31:0]   wdata,
  input wire logic          wr,
  input wire logic          rd,
  input wire logic          remote_src,
  input wire logic [31:0]   rdata,
  // Pressure and pins
  input wire logic [PW-1:0] pressure,
  input wire logic          pressure_tick,
  input wire logic          external_command_line_n,
  input wire logic          start_btn,
  input wire logic          stop_btn,
  input wire logic          net_menu,
  input wire logic          power_restart,
  input wire logic [3:0]    peer_present,
  input wire logic [3:0]    peer_active,
  // Outputs
  input wire logic          load_valve,
  input wire logic          motor_run,
  input wire logic          confirm,
  input wire logic          ready,
  input wire logic          remote_disabled,
  input wire logic          net_active,
  input wire logic [3:0]    unit_start,
  input wire logic          search
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);

  valve_needs_motor_a: assert property (load_valve |-> motor_run)
    else $error("valve open with motor stopped");
  confirm_needs_motor_a: assert property (confirm |-> motor_run)
    else $error("confirm high with motor stopped");
  confirm_rise_a: assert property ($rose(confirm) |-> load_valve)
    else $error("confirm rose without compression");
  ready_idle_a: assert property (ready |-> !motor_run && !load_valve)
    else $error("motor runs in ready state");
  disabled_stop_a: assert property (remote_disabled |-> !motor_run && !ready)
    else $error("disabled unit not stopped");
  start_pulse_a: assert property (unit_start != 4'h0 |->
    $onehot(unit_start) && net_active ##1 unit_start == 4'h0)
    else $error("bad unit start pulse");
  search_pulse_a: assert property (search |=> !search)
    else $error("search pulse too long");
  net_search_a: assert property ($rose(net_active) |-> search ##1 unit_start != 4'h0)
    else $error("network start without search and first start");

  cover property ($rose(net_active));
  cover property ($fell(motor_run));
  cover property ($rose(remote_disabled));
endmodule

bind compressor_ctrl compressor_chk #(.PW(PW), .SEC_TICKS(SEC_TICKS)) chk (.*);
`default_nettype wire

//--- test/remote_panel.sv
`timescale 1ns/100ps
`default_nettype none
module remote_panel (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rstn,
  // Bench requests
  input  wire logic       want_load,
  input  wire logic [3:0] lag,
  input  wire logic [3:0] units_up,
  // Lines toward the controller
  output logic            line_n,
  output logic [3:0]      present,
  output logic [3:0]      active
);
  logic [3:0] wait_r;

  // Line follows the request lag+1 cycles later, so slow panels are covered
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_r  <= 4'h0;
      line_n  <= 1'b1;
      present <= 4'h0;
      active  <= 4'h0;
    end else begin
      present <= units_up;
      active  <= units_up;
      if (line_n != want_load) begin
        wait_r <= 4'h0;
      end else if (wait_r >= lag) begin
        wait_r <= 4'h0;
        line_n <= ~want_load;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int TK = 10;
  logic        clock, rstn, wr, rd, remote_src, tk, start_btn, stop_btn, net_menu, pwr;
  logic        want_load, rd_seen, line_n, valve, motor, confirm, ready, dis, net_act, search;
  logic [7:0]  addr;
  logic [15:0] pressure;
  logic [3:0]  lag, units_up, unit_start, present, active;
  logic [31:0] wdata, rdata, e, g, m, exp_q[$], msk_q[$], st_q[$];
  int          miscompares, comparisons, cyc, last_cyc, srch_n;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  compressor_ctrl #(.PW(16), .SEC_TICKS(TK)) uut (.clock(clock), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .remote_src(remote_src), .rdata(rdata),
    .pressure(pressure), .pressure_tick(tk), .external_command_line_n(line_n),
    .start_btn(start_btn), .stop_btn(stop_btn), .net_menu(net_menu), .power_restart(pwr),
    .peer_present(present), .peer_active(active), .load_valve(valve), .motor_run(motor),
    .confirm(confirm), .ready(ready), .remote_disabled(dis), .net_active(net_act),
    .unit_start(unit_start), .search(search));
  remote_panel panel (.clock(clock), .rstn(rstn), .want_load(want_load), .lag(lag),
    .units_up(units_up), .line_n(line_n), .present(present), .active(active));

  task automatic check_word(input logic [31:0] got, input logic [31:0] ex, input logic [31:0] m);
    comparisons++;
    if ((got & m) !== (ex & m)) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got & m, ex & m);
    end
  endtask
  task automatic check_start(input logic [31:0] got, input logic [31:0] ex);
    check_word(got, ex, 32'hffffffff);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic src);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    remote_src <= src;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m);
    exp_q.push_back(ex);
    msk_q.push_back(m);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
  endtask
  task automatic stat(input logic [31:0] ex);
    rd_check(8'h1c, ex, 32'h1ff);
  endtask
  task automatic press(input logic stop);
    @(posedge clock);
    if (stop) stop_btn <= 1'b1;
    else start_btn <= 1'b1;
    repeat (4) @(posedge clock);
    start_btn <= 1'b0;
    stop_btn <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task automatic tick(input logic [15:0] p);
    @(posedge clock);
    pressure <= p;
    tk <= 1'b1;
    @(posedge clock);
    tk <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  function automatic logic [15:0] hi();
    return 16'h50 + 16'($urandom % 32);
  endfunction
  function automatic logic [15:0] lo();
    return 16'($urandom % 60);
  endfunction
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Results checked at the falling edge, well clear of the launching edge
  always @(posedge clock) begin
    rd_seen <= rd;
    cyc <= cyc + 1;
  end
  always @(negedge clock) begin
    if (search) srch_n++;
    if (rd_seen) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check_word(rdata, e, m);
      // Status reads also hold the output pins against the same expectation
      if (m inside {32'h1ff, 32'h200, 32'h7ff}) begin
        g = {22'h0, net_act, dis, confirm, motor, valve, 3'h0, ready, 1'b0};
        check_word(g, e, m & 32'h3e2);
      end
    end
    if (unit_start !== 4'h0) begin
      e = st_q.pop_front();
      g = {28'(cyc - last_cyc), unit_start};
      if (e[31:4] == 28'h0) g[31:4] = 28'h0;
      check_start(g, e);
      last_cyc = cyc;
    end
  end

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    tally_and_finish();
  end

  logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h24};
  logic [31:0] rv[7] = '{32'h0, 32'h3c, 32'h50, 32'hb4, 32'h5, 32'ha, 32'h0};
  logic [15:0] h;
  initial begin
    {rstn, wr, rd, remote_src, tk, start_btn, stop_btn, net_menu, want_load, pwr} = 10'h000;
    addr = 8'h0;
    wdata = 32'h0;
    pressure = 16'h0;
    lag = 4'h1;
    units_up = 4'h0;
    void'($urandom(52));
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    foreach (ra[i]) rd_check(ra[i], rv[i], 32'hffffffff);
    h = 16'($urandom);
    wr_reg(8'h10, {16'h0, h}, 1'b0);
    rd_check(8'h10, {16'h0, h}, 32'hffffffff);
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h00, 32'(m), 1'b0);
      rd_check(8'h00, 32'(m), 32'h3);
    end
    wr_reg(8'h04, 32'h11, 1'b1);
    wr_reg(8'h00, 32'h0, 1'b1);
    rd_check(8'h04, 32'h3c, 32'hffff);
    rd_check(8'h00, 32'h3, 32'h3);
    wr_reg(8'h00, 32'h0, 1'b0);
    wr_reg(8'h0c, 32'h2, 1'b0);
    press(1'b0);
    stat(32'he4);
    tick(hi());
    stat(32'hc8);
    tick(lo());
    stat(32'he4);
    tick(hi());
    repeat (2 * TK + 8) @(posedge clock);
    stat(32'h10);
    tick(lo());
    stat(32'he4);
    press(1'b1);
    wr_reg(8'h00, 32'h1, 1'b0);
    press(1'b0);
    tick(hi());
    repeat (3 * TK) @(posedge clock);
    stat(32'hc8);
    tick(16'h3c);
    stat(32'he4);
    press(1'b1);
    wr_reg(8'h00, 32'h2, 1'b0);
    press(1'b0);
    stat(32'h02);
    want_load <= 1'b1;
    lag <= 4'h5;
    repeat (12) @(posedge clock);
    stat(32'he4);
    want_load <= 1'b0;
    repeat (12) @(posedge clock);
    stat(32'hc8);
    wr_reg(8'h18, 32'h1, 1'b1);
    stat(32'he4);
    wr_reg(8'h18, 32'h2, 1'b1);
    stat(32'hc8);
    press(1'b1);
    stat(32'h101);
    wr_reg(8'h18, 32'h1, 1'b1);
    stat(32'h101);
    press(1'b0);
    stat(32'h02);
    wr_reg(8'h00, 32'h6, 1'b0);
    want_load <= 1'b1;
    repeat (12) @(posedge clock);
    stat(32'h10);
    want_load <= 1'b0;
    repeat (12) @(posedge clock);
    stat(32'h02);
    wr_reg(8'h10, 32'h2, 1'b0);
    wr_reg(8'h00, 32'ha, 1'b0);
    pwr <= 1'b1;
    want_load <= 1'b1;
    repeat (10) @(posedge clock);
    rd_check(8'h1c, 32'h402, 32'h7ff);
    repeat (20) @(posedge clock);
    stat(32'he4);
    pwr <= 1'b0;
    want_load <= 1'b0;
    press(1'b1);
    wr_reg(8'h00, 32'h10, 1'b0);
    wr_reg(8'h14, 32'h3, 1'b0);
    net_menu <= 1'b1;
    press(1'b0);
    rd_check(8'h1c, 32'h0, 32'h200);
    units_up <= 4'h5;
    st_q.push_back(32'h1);
    st_q.push_back({28'(3 * TK + 2), 4'h4});
    press(1'b0);
    rd_check(8'h1c, 32'h200, 32'h200);
    repeat (50) @(posedge clock);
    check_start(32'(st_q.size()), 32'h0);
    check_word(32'(srch_n), 32'h2, 32'hffffffff);
    units_up <= 4'h0;
    repeat (10) @(posedge clock);
    rd_check(8'h1c, 32'h0, 32'h200);
    repeat (4) @(posedge clock);
    tally_and_finish();
  end
endmodule
`default_nettype wire
